// [logic/analyzer_trigger.sv]
/*
 * Trigger, event-counter and storage-qualification core of a bus-state
 * analyzer. Samples the system-under-test bus once per bus clock, judges
 * each cycle against word matchers, fires the trigger, runs the post-trigger
 * delay and counters, and flags which samples go to acquisition memory.
 * Assumes the bus pins are asynchronous to core_clk_i and that the bus clock
 * is well below a third of the core rate. Registers sit on a simple port.
 */
// The plain strobed port and the register offsets were left to the implementer.
// Functional notes
// - Counters run until terminal or acquisition end
// - Delay reaching target ends acquisition, stops counters
// - After-data position shortens post-trigger acquisition
// - Zero delay stops counters next bus cycle
// - Counters count up by one per event
// - Inversion complements only the following event
// - Reject inversion outside brackets or before close
// - Interrupt fields compare active low
// - Inverted no-interrupt matcher triggers on any interrupt
// - Qualified mode stores only matching bus cycles
// - One qualify condition applies to all tests
module analyzer_trigger
    import analyzer_pkg::*;
#(
    parameter int N_MATCH = 2,
    parameter int N_CNT = 2,
    parameter int CNT_W = 16,
    parameter int DELAY_W = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // System-under-test bus pins
    input wire logic sut_clk_i,
    input wire logic [7:0] sut_data_i,
    input wire logic [15:0] sut_addr_i,
    input wire logic [7:0] sut_ctl_i,
    // Acquisition side
    output logic store_en_o,
    output logic [31:0] store_word_o,
    output logic trigger_o,
    output logic acq_done_o,
    // Interrupt
    output logic irq_o
);

    if (N_MATCH != 2 || N_CNT < 1 || N_CNT > 4
        || DELAY_W < 4 || DELAY_W > 16) begin : g_param_check
        $error("analyzer_trigger: parameter out of range");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_POST, ST_DONE} acq_state_t;

    // ------------------------------------------------------------
    // Clause helpers
    // ------------------------------------------------------------
    // An inversion binds to its own term only; the other term is untouched
    function automatic logic clause_eval(input logic [7:0] cl, input logic [1:0] hit);
        logic t0;
        logic t1;
        t0 = hit[0] ^ cl[CL_T0_INV];
        t1 = hit[1] ^ cl[CL_T1_INV];
        if (!cl[CL_BRACKET]) begin
            clause_eval = cl[CL_T0_EN] && t0;
        end else if (cl[CL_AND]) begin
            clause_eval = (!cl[CL_T0_EN] || t0) && (!cl[CL_T1_EN] || t1)
                && (cl[CL_T0_EN] || cl[CL_T1_EN]);
        end else begin
            clause_eval = (cl[CL_T0_EN] && t0) || (cl[CL_T1_EN] && t1);
        end
    endfunction

    // Inversion only in brackets, and never with nothing after it
    function automatic logic clause_bad(input logic [7:0] cl);
        logic any_inv;
        any_inv = cl[CL_T0_INV] || cl[CL_T1_INV];
        clause_bad = (any_inv && !cl[CL_BRACKET])
            || (cl[CL_T0_INV] && !cl[CL_T0_EN])
            || (cl[CL_T1_INV] && !cl[CL_T1_EN]);
    endfunction

    // Post-trigger length per position; later trigger leaves fewer cycles
    function automatic logic [DELAY_W-1:0] post_target(input logic [DELAY_W-1:0] d,
                                                       input logic [1:0] pos);
        logic [DELAY_W-1:0] t;
        case (pos)
            POS_BEFORE: t = d;
            POS_CENTER: t = d >> 1;
            POS_AFTER: t = d >> 2;
            default: t = '0;
        endcase
        post_target = (t == '0) ? DELAY_W'(1) : t;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and bus clock edge
    // ------------------------------------------------------------
    // Three stages; a level counts once stages two and three agree
    logic [32:0] pin_s1_r;
    logic [32:0] pin_s2_r;
    logic [32:0] pin_s3_r;
    logic bus_clk_f_r;
    logic bus_edge;
    logic [31:0] word_r;
    logic sample_v_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            pin_s1_r <= {sut_clk_i, sut_ctl_i, sut_addr_i, sut_data_i};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    assign bus_edge = (pin_s2_r[32] == pin_s3_r[32]) && pin_s3_r[32] && !bus_clk_f_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bus_clk_f_r <= 1'b0;
        end else if (pin_s2_r[32] == pin_s3_r[32]) begin
            bus_clk_f_r <= pin_s3_r[32];
        end
    end

    // Data and control lines settle long before the bus clock edge
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            word_r <= '0;
            sample_v_r <= 1'b0;
        end else begin
            sample_v_r <= bus_edge;
            if (bus_edge) begin
                word_r <= pin_s3_r[31:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Program registers
    // ------------------------------------------------------------
    logic [1:0] pos_r;
    logic [DELAY_W-1:0] delay_r;
    logic [7:0] clause_r;
    logic [8:0] qual_r;
    logic [31:0] mval_r [N_MATCH];
    logic [31:0] mcare_r [N_MATCH];
    logic [CNT_W-1:0] term_r [N_CNT];
    logic [N_CNT-1:0] csel_r;
    logic [EV_W-1:0] irq_en_r;
    logic start_req;
    logic abort_req;
    logic clr_req;

    assign start_req = reg_wr_i && (reg_addr_i == OFF_CTRL) && reg_wdata_i[CTRL_START_BIT];
    assign abort_req = reg_wr_i && (reg_addr_i == OFF_CTRL) && reg_wdata_i[CTRL_ABORT_BIT];
    assign clr_req = reg_wr_i && (reg_addr_i == OFF_IRQ_CLR);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pos_r <= POS_BEFORE;
            delay_r <= DELAY_RST[DELAY_W-1:0];
            clause_r <= CLAUSE_RST;
            qual_r <= '0;
            irq_en_r <= '0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == OFF_CTRL) begin
                pos_r <= reg_wdata_i[CTRL_POS_LSB +: 2];
            end else if (reg_addr_i == OFF_IRQ_EN) begin
                irq_en_r <= reg_wdata_i[EV_W-1:0];
            end else if (reg_addr_i == OFF_DELAY) begin
                delay_r <= reg_wdata_i[DELAY_W-1:0];
            end else if (reg_addr_i == OFF_CLAUSE) begin
                clause_r <= reg_wdata_i[7:0];
            end else if (reg_addr_i == OFF_QUAL) begin
                qual_r <= reg_wdata_i[8:0];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < N_MATCH; i++) begin
                mval_r[i] <= '0;
                mcare_r[i] <= MASK_RST;
            end
            for (int i = 0; i < N_CNT; i++) begin
                term_r[i] <= TERM_RST[CNT_W-1:0];
                csel_r[i] <= 1'b0;
            end
        end else if (reg_wr_i) begin
            for (int i = 0; i < N_MATCH; i++) begin
                if (reg_addr_i == OFF_MATCH_BASE + 8'(i) * OFF_STRIDE) begin
                    mval_r[i] <= reg_wdata_i;
                end else if (reg_addr_i == OFF_MATCH_BASE + 8'(i) * OFF_STRIDE + OFF_SECOND) begin
                    mcare_r[i] <= reg_wdata_i;
                end
            end
            for (int i = 0; i < N_CNT; i++) begin
                if (reg_addr_i == OFF_CNT_BASE + 8'(i) * OFF_STRIDE) begin
                    term_r[i] <= reg_wdata_i[CNT_W-1:0];
                    csel_r[i] <= reg_wdata_i[CNT_SEL_BIT];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Matchers and event clauses
    // ------------------------------------------------------------
    logic [1:0] hit;
    logic trig_hit;
    logic qual_hit;
    logic prog_bad;

    for (genvar g = 0; g < N_MATCH; g++) begin : g_match
        word_matcher #(
            .WORD_W(32)
        ) u_match (
            .value_i(mval_r[g]),
            .care_i(mcare_r[g]),
            .word_i(word_r),
            .match_o(hit[g])
        );
    end

    // An inverted idle-interrupt matcher becomes true on any asserted line
    assign trig_hit = clause_eval(clause_r, hit);
    // The single qualify clause is global, whatever the test position
    assign qual_hit = !qual_r[QUAL_ON_BIT] || clause_eval(qual_r[7:0], hit);
    assign prog_bad = clause_bad(clause_r) || clause_bad(qual_r[7:0]);

    // ------------------------------------------------------------
    // Acquisition sequence
    // ------------------------------------------------------------
    acq_state_t state_r;
    logic [DELAY_W-1:0] post_cnt_r;
    logic [DELAY_W-1:0] target_r;
    logic running;
    logic post_last;

    assign running = (state_r == ST_PRE) || (state_r == ST_POST);
    assign post_last = (state_r == ST_POST) && sample_v_r
        && (post_cnt_r + 1'b1 >= target_r);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            post_cnt_r <= '0;
            target_r <= '0;
        end else if (abort_req) begin
            state_r <= ST_IDLE;
        end else if (start_req && !prog_bad) begin
            state_r <= ST_PRE;
            post_cnt_r <= '0;
            // Position written with start applies to this run, not the next
            target_r <= post_target(delay_r, reg_wdata_i[CTRL_POS_LSB +: 2]);
        end else begin
            case (state_r)
                ST_PRE: begin
                    if (sample_v_r && trig_hit) begin
                        state_r <= ST_POST;
                        post_cnt_r <= '0;
                    end
                end
                ST_POST: begin
                    if (post_last) begin
                        state_r <= ST_DONE;
                    end else if (sample_v_r) begin
                        post_cnt_r <= post_cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Event counters
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_val [N_CNT];
    logic [N_CNT-1:0] cnt_term;
    logic cnt_clear;

    assign cnt_clear = start_req && !prog_bad;

    for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
        // Counting stops together with the acquisition, terminal or not
        event_counter #(
            .CNT_W(CNT_W)
        ) u_cnt (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .clear_i(cnt_clear),
            .run_i(running),
            .event_i(sample_v_r && hit[csel_r[g]]),
            .terminal_i(term_r[g]),
            .value_o(cnt_val[g]),
            .at_term_o(cnt_term[g])
        );
    end

    // ------------------------------------------------------------
    // Storage and outputs
    // ------------------------------------------------------------
    logic [15:0] stored_r;
    logic [15:0] trig_loc_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            store_en_o <= 1'b0;
            store_word_o <= '0;
            stored_r <= '0;
        end else begin
            store_en_o <= running && sample_v_r && qual_hit;
            store_word_o <= word_r;
            if (cnt_clear) begin
                stored_r <= '0;
            end else if (running && sample_v_r && qual_hit) begin
                stored_r <= stored_r + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            trigger_o <= 1'b0;
            acq_done_o <= 1'b0;
            trig_loc_r <= '0;
        end else begin
            trigger_o <= (state_r == ST_PRE) && sample_v_r && trig_hit && !abort_req;
            acq_done_o <= (state_r == ST_DONE);
            if ((state_r == ST_PRE) && sample_v_r && trig_hit) begin
                trig_loc_r <= stored_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    logic [EV_W-1:0] status_r;
    logic [EV_W-1:0] ev_set;

    assign ev_set[EV_TRIG] = (state_r == ST_PRE) && sample_v_r && trig_hit;
    assign ev_set[EV_DONE] = post_last;
    assign ev_set[EV_REJECT] = start_req && prog_bad;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status_r <= '0;
            irq_o <= 1'b0;
        end else begin
            status_r <= (status_r & ~(clr_req ? reg_wdata_i[EV_W-1:0] : '0)) | ev_set;
            irq_o <= |(status_r & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (reg_addr_i == OFF_CTRL) begin
            rd_mux[CTRL_POS_LSB +: 2] = pos_r;
            rd_mux[CTRL_CLAUSE_BAD_BIT] = clause_bad(clause_r);
            rd_mux[CTRL_QUAL_BAD_BIT] = clause_bad(qual_r[7:0]);
            rd_mux[CTRL_STATE_LSB +: 2] = state_r;
        end else if (reg_addr_i == OFF_STATUS) begin
            rd_mux[EV_W-1:0] = status_r;
        end else if (reg_addr_i == OFF_IRQ_EN) begin
            rd_mux[EV_W-1:0] = irq_en_r;
        end else if (reg_addr_i == OFF_DELAY) begin
            rd_mux[DELAY_W-1:0] = delay_r;
        end else if (reg_addr_i == OFF_CLAUSE) begin
            rd_mux[7:0] = clause_r;
        end else if (reg_addr_i == OFF_QUAL) begin
            rd_mux[8:0] = qual_r;
        end else if (reg_addr_i == OFF_TRIG_LOC) begin
            rd_mux[15:0] = trig_loc_r;
        end else begin
            for (int i = 0; i < N_MATCH; i++) begin
                if (reg_addr_i == OFF_MATCH_BASE + 8'(i) * OFF_STRIDE) begin
                    rd_mux = mval_r[i];
                end else if (reg_addr_i == OFF_MATCH_BASE + 8'(i) * OFF_STRIDE + OFF_SECOND) begin
                    rd_mux = mcare_r[i];
                end
            end
            for (int i = 0; i < N_CNT; i++) begin
                if (reg_addr_i == OFF_CNT_BASE + 8'(i) * OFF_STRIDE) begin
                    rd_mux[CNT_W-1:0] = term_r[i];
                    rd_mux[CNT_SEL_BIT] = csel_r[i];
                end else if (reg_addr_i == OFF_CNT_BASE + 8'(i) * OFF_STRIDE + OFF_SECOND) begin
                    rd_mux[CNT_W-1:0] = cnt_val[i];
                    rd_mux[31] = cnt_term[i];
                end
            end
        end
    end

    // Unread cycles return zero so a stale word is never mistaken for data
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

// [logic/analyzer_pkg.sv]
/*
 * Shared constants for the bus-state trigger and qualification block:
 * register offsets, field positions, reset values and count widths.
 * Assumes a byte-addressed register port with one 32-bit word per register.
 */
package analyzer_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_EN = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
    localparam logic [7:0] OFF_DELAY = 8'h10;
    localparam logic [7:0] OFF_CLAUSE = 8'h14;
    localparam logic [7:0] OFF_QUAL = 8'h18;
    localparam logic [7:0] OFF_TRIG_LOC = 8'h1C;
    localparam logic [7:0] OFF_MATCH_BASE = 8'h20;
    localparam logic [7:0] OFF_CNT_BASE = 8'h40;
    localparam logic [7:0] OFF_STRIDE = 8'h08;
    localparam logic [7:0] OFF_SECOND = 8'h04;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    localparam int CTRL_POS_LSB = 2;
    localparam int CTRL_CLAUSE_BAD_BIT = 8;
    localparam int CTRL_QUAL_BAD_BIT = 9;
    localparam int CTRL_STATE_LSB = 12;

    // Trigger positions
    localparam logic [1:0] POS_BEFORE = 2'h0;
    localparam logic [1:0] POS_CENTER = 2'h1;
    localparam logic [1:0] POS_AFTER = 2'h2;
    localparam logic [1:0] POS_ZERO = 2'h3;

    // ------------------------------------------------------------
    // Event clause layout (trigger and qualify share it)
    // ------------------------------------------------------------
    localparam int CL_T0_EN = 0;
    localparam int CL_T0_INV = 1;
    localparam int CL_T1_EN = 2;
    localparam int CL_T1_INV = 3;
    localparam int CL_BRACKET = 4;
    localparam int CL_AND = 5;
    localparam int QUAL_ON_BIT = 8;

    // Counter configuration: terminal value low, event select above
    localparam int CNT_SEL_BIT = 16;
    localparam logic CNT_MODE_COUNT_UP = 1'b0;

    // Status / interrupt bits
    localparam int EV_TRIG = 0;
    localparam int EV_DONE = 1;
    localparam int EV_REJECT = 2;
    localparam int EV_W = 3;

    // ------------------------------------------------------------
    // Sampled bus word layout
    // ------------------------------------------------------------
    localparam int BW_DATA_LSB = 0;
    localparam int BW_ADDR_LSB = 8;
    localparam int BW_CTL_LSB = 24;
    localparam int BW_NMI_N = 24;
    localparam int BW_IRQ_N = 25;

    // Reset values
    localparam logic [15:0] DELAY_RST = 16'h0000;
    localparam logic [7:0] CLAUSE_RST = 8'h01;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [15:0] TERM_RST = 16'hFFFF;

endpackage

// [logic/word_matcher.sv]
/*
 * One word matcher: compares a sampled bus word against a programmed value
 * under a care mask. Assumes the word is stable for the cycle it is judged.
 */
module word_matcher
    import analyzer_pkg::*;
#(
    parameter int WORD_W = 32
) (
    // Program
    input wire logic [WORD_W-1:0] value_i,
    input wire logic [WORD_W-1:0] care_i,
    // Sampled bus word
    input wire logic [WORD_W-1:0] word_i,
    // Result
    output logic match_o
);

    // Interrupt lines arrive at pin level, so a programmed 1 means idle line
    // Cleared care bits are do-not-care fields
    assign match_o = (((word_i ^ value_i) & care_i) == '0);

endmodule

// [logic/event_counter.sv]
/*
 * Event counter: counts up by one per qualifying event until its terminal
 * value, then holds. Assumes the parent drops run_i at acquisition end.
 */
module event_counter
    import analyzer_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clear_i,
    input wire logic run_i,
    input wire logic event_i,
    input wire logic [CNT_W-1:0] terminal_i,
    // State
    output logic [CNT_W-1:0] value_o,
    output logic at_term_o
);

    if (CNT_W < 2 || CNT_W > 16) begin : g_width_check
        $error("event_counter: CNT_W out of range");
    end

    logic [CNT_W-1:0] value_r;

    assign value_o = value_r;
    assign at_term_o = (value_r == terminal_i);

    always_ff @(posedge core_clk_i) begin
        if (rst_i || clear_i) begin
            value_r <= '0;
        end else if (run_i && event_i && !at_term_o) begin
            value_r <= value_r + 1'b1;
        end
    end

endmodule

// [bench/sut_bus_model.sv]
/* Model of the system-under-test bus: one sampled bus cycle per call.
   Assumes the bench's 100 MHz core clock paces it. */
module sut_bus_model (
    // Clock
    input wire logic core_clk_i,
    // Bus pins
    output logic sut_clk_o,
    output logic [31:0] sut_word_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sut_clk_o = 1'b0;
        sut_word_o = 32'h0;
    end
    // Pins held 4 core cycles before the rising edge and 8 after it
    task automatic cyc(input logic [31:0] w);
        @(posedge core_clk_i);
        sut_word_o <= w;
        repeat (4) @(posedge core_clk_i);
        sut_clk_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        sut_clk_o <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        // Hold over: pins no longer carry the word
        sut_word_o <= ~w;
    endtask
endmodule

// [bench/analyzer_trigger_sva.sv]
/* Port checker for the trigger block.
   Assumes bus clock high phases of 4 core cycles, as the bench makes. */
module analyzer_trigger_sva (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic sut_clk_i,
    input wire logic store_en_o,
    input wire logic trigger_o,
    input wire logic acq_done_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence bus_rise;
        !sut_clk_i ##1 sut_clk_i;
    endsequence
    sequence one_pulse(s);
        s ##1 !s;
    endsequence
    rst_quiet_a: assert property (disable iff (1'b0) rst_i |=>
        !(trigger_o | store_en_o | acq_done_o | irq_o) && reg_rdata_o == 32'h0)
        else $error("outputs not quiet after reset");
    trig_pulse_a: assert property (trigger_o |-> one_pulse(trigger_o))
        else $error("trigger longer than one cycle");
    store_pulse_a: assert property (store_en_o |-> one_pulse(store_en_o))
        else $error("store strobe longer than one cycle");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data without read");
    done_no_trig_a: assert property (acq_done_o |-> !trigger_o)
        else $error("trigger after acquisition end");
    done_no_store_a: assert property (acq_done_o && $past(acq_done_o) |-> !store_en_o)
        else $error("store after acquisition end");
    store_cause_a: assert property (store_en_o |-> $past(sut_clk_i, 3) || $past(sut_clk_i, 4))
        else $error("store without bus clock edge");
    done_exit_a: assert property ($fell(acq_done_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
        else $error("acquisition end dropped without write");
    store_seen_c: cover property (bus_rise ##[4:8] store_en_o);
endmodule

// [bench/analyzer_trigger_bench.sv]
/* Self-checking bench for analyzer_trigger with a bus model.
   Assumes the register map and timing of the package. */
module analyzer_trigger_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import analyzer_pkg::*;
    logic core_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, sut_clk_i;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, store_word_o, w, rd_v, last_w;
    logic store_en_o, trigger_o, acq_done_o, irq_o;
    int num_errors = 0, samples_checked = 0, stores = 0, trigs = 0;
    analyzer_trigger analyzer_trigger_i (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sut_clk_i, .sut_data_i(w[7:0]),
        .sut_addr_i(w[23:8]), .sut_ctl_i(w[31:24]), .store_en_o, .store_word_o,
        .trigger_o, .acq_done_o, .irq_o);
    sut_bus_model sut_bus_model_i (.core_clk_i, .sut_clk_o(sut_clk_i), .sut_word_o(w));
    initial forever #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (trigger_o === 1'b1) trigs++;
    always @(posedge core_clk_i) if (store_en_o === 1'b1) begin
        stores++;
        last_w = store_word_o;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_v = reg_rdata_o;
        @(posedge core_clk_i);
        chk(rd_v, exp);
    endtask
    task automatic wait_done;
        for (int i = 0; i < 400 && acq_done_o !== 1'b1; i++) @(posedge core_clk_i);
        if (acq_done_o !== 1'b1) begin
            num_errors++;
            complete_run();
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_positions;
        wr(OFF_MATCH_BASE, 32'h00F8_2F00);
        wr(OFF_MATCH_BASE + OFF_SECOND, 32'h00FF_FF00);
        wr(OFF_CNT_BASE, 32'h0000_0003);
        wr(OFF_CNT_BASE + OFF_STRIDE, 32'h0001_FFFF);
        wr(OFF_DELAY, 32'h8);
        wr(OFF_IRQ_EN, 32'h2);
        for (int k = 0; k < 4; k++) begin
            wr(OFF_CTRL, 32'(1 | k << 2));
            sut_bus_model_i.cyc(32'h0300_1200);
            for (int j = 0; j < 10; j++) sut_bus_model_i.cyc(32'h03F8_2F00);
            wait_done();
            rchk(OFF_CNT_BASE + OFF_SECOND, k == 3 ? 32'h2 : 32'h8000_0003);
            rchk(OFF_CNT_BASE + OFF_STRIDE + OFF_SECOND, 32'((k == 3 ? 1 : 8 >> k) + 2));
            rchk(OFF_TRIG_LOC, 32'h1);
            rchk(OFF_STATUS, 32'h3);
            chk(32'(irq_o), 32'h1);
            wr(OFF_IRQ_CLR, 32'h7);
            @(posedge core_clk_i);
            chk(32'(irq_o), 32'h0);
        end
        $display("positions done");
    endtask
    task automatic test_interrupts;
        wr(OFF_MATCH_BASE, 32'h0300_0000);
        wr(OFF_MATCH_BASE + OFF_SECOND, 32'h0300_0000);
        wr(OFF_CLAUSE, 32'h37);
        wr(OFF_CTRL, 32'h0D);
        repeat (2) sut_bus_model_i.cyc(32'h0300_0000);
        sut_bus_model_i.cyc(32'h0100_0000);
        sut_bus_model_i.cyc(32'h0300_0000);
        wait_done();
        rchk(OFF_TRIG_LOC, 32'h2);
        chk(32'(trigs), 32'h5);
        rchk(OFF_STATUS, 32'h3);
        wr(OFF_IRQ_CLR, 32'h7);
        $display("interrupts done");
    endtask
    task automatic test_reject;
        logic [7:0] bad [2] = '{8'h03, 8'h18};
        for (int k = 0; k < 2; k++) begin
            wr(OFF_CLAUSE, 32'(bad[k]));
            wr(OFF_CTRL, 32'h01);
            rchk(OFF_STATUS, 32'h4);
            rchk(OFF_CTRL, 32'h3100);
            wr(OFF_IRQ_CLR, 32'h7);
        end
        $display("reject done");
    endtask
    task automatic test_qualify;
        logic [31:0] s [6] = '{32'h0700_1200, 32'h0300_1200, 32'h0700_1200,
            32'h07F8_2F00, 32'h0300_1200, 32'h0700_1200};
        wr(OFF_CLAUSE, 32'h01);
        wr(OFF_MATCH_BASE, 32'h00F8_2F00);
        wr(OFF_MATCH_BASE + OFF_SECOND, 32'h00FF_FF00);
        wr(OFF_MATCH_BASE + OFF_STRIDE, 32'h0400_0000);
        wr(OFF_MATCH_BASE + OFF_STRIDE + OFF_SECOND, 32'h0400_0000);
        wr(OFF_QUAL, 32'h114);
        wr(OFF_DELAY, 32'h2);
        wr(OFF_CTRL, 32'h01);
        stores = 0;
        for (int j = 0; j < 6; j++) sut_bus_model_i.cyc(s[j]);
        wait_done();
        chk(32'(stores), 32'h4);
        chk(last_w, 32'h0700_1200);
        rchk(OFF_TRIG_LOC, 32'h2);
        $display("qualify done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        rchk(OFF_CLAUSE, 32'h01);
        rchk(OFF_DELAY, 32'h0);
        rchk(8'hFC, 32'h0);
        test_positions();
        test_interrupts();
        test_reject();
        test_qualify();
        complete_run();
    end
endmodule
bind analyzer_trigger analyzer_trigger_sva analyzer_trigger_sva_i (.core_clk_i, .rst_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sut_clk_i, .store_en_o, .trigger_o,
    .acq_done_o, .irq_o);
